// ---- verilog/divp_consts.vh ----
// constants for the interrupt vector and priority block
`ifndef DIVP_CONSTS_VH
`define DIVP_CONSTS_VH
// vector offsets (words from vector base)
`define DIVP_VEC_RESET    7'h00
`define DIVP_VEC_NMI      7'h04
`define DIVP_VEC_EXT0     7'h40
`define DIVP_VEC_EXT1     7'h44
`define DIVP_VEC_TIMER    7'h4C
`define DIVP_VEC_SER0RX   7'h50
`define DIVP_VEC_SER0TX   7'h54
`define DIVP_VEC_SHR0     7'h58
`define DIVP_VEC_SHR1     7'h5C
`define DIVP_VEC_HOST     7'h64
`define DIVP_VEC_SHR2     7'h68
`define DIVP_VEC_SHR3     7'h6C
`define DIVP_VEC_DMA4     7'h70
`define DIVP_VEC_DMA5     7'h74
`define DIVP_VEC_IPROC    7'h78
// slot spacing in words
`define DIVP_SLOT_STEP    7'h04
// flag and mask bit positions
`define DIVP_BIT_EXT0     0
`define DIVP_BIT_EXT1     1
`define DIVP_BIT_TIMER    3
`define DIVP_BIT_SER0RX   4
`define DIVP_BIT_SER0TX   5
`define DIVP_BIT_SHR0     6
`define DIVP_BIT_SHR1     7
`define DIVP_BIT_HOST     9
`define DIVP_BIT_SHR2     10
`define DIVP_BIT_SHR3     11
`define DIVP_BIT_DMA4     12
`define DIVP_BIT_DMA5     13
`define DIVP_BIT_IPROC    14
// bits that carry a source; 2, 8 and 15 are reserved
`define DIVP_FLAG_USED    16'h7EFB
`define DIVP_FLAG_RESET   16'h0000
// priorities of reset and nmi, and the value offered when nothing is pending
`define DIVP_PRI_RESET    5'h01
`define DIVP_PRI_NMI      5'h02
`define DIVP_PRI_NONE     5'h1F
`endif

// ---- verilog/divp_edge_latch.v ----
// one sticky flag with rising edge capture
`timescale 1ns/1ps
module divp_edge_latch (
    clk_sys,
    rst_n,
    srcLevel,
    clrPulse,
    flagOut
);
    input  wire clk_sys;
    input  wire rst_n;
    input  wire srcLevel;
    input  wire clrPulse;
    output wire flagOut;

    reg srcPrev_ff;
    reg flag_ff;
    wire riseSeen;

    assign riseSeen = srcLevel & ~srcPrev_ff;
    assign flagOut  = flag_ff;

    // capture edge; a new edge wins over a clear in the same cycle
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            srcPrev_ff <= 1'b0;
            flag_ff    <= 1'b0;
        end else begin
            srcPrev_ff <= srcLevel;
            if (riseSeen)
                flag_ff <= 1'b1;
            else if (clrPulse)
                flag_ff <= 1'b0;
        end
    end
endmodule // divp_edge_latch

// ---- verilog/divp_pri_encode.v ----
// lowest set bit finder for pending flags
`timescale 1ns/1ps
module divp_pri_encode (
    reqBits,
    anyReq,
    winIdx
);
    input  wire [15:0] reqBits;
    output reg         anyReq;
    output reg  [3:0]  winIdx;

    integer i;

    // scan from the top so the lowest bit is left standing
    always @* begin
        anyReq = 1'b0;
        winIdx = 4'h0;
        for (i = 15; i >= 0; i = i - 1) begin
            if (reqBits[i]) begin
                anyReq = 1'b1;
                winIdx = i[3:0];
            end
        end
    end
endmodule // divp_pri_encode

// ---- verilog/divp_vector_priority.v ----
// interrupt vector and priority logic for one processor subsystem
`timescale 1ns/1ps
`include "divp_consts.vh"
// Summary of operation
// - each source, or shared serial/dma pair, owns a slot four words apart from the vector base.
// - hardware or software reset goes to offset 0 with priority 1.
// - external request zero goes to offset 40h with priority 3.
// - external request one goes to offset 44h with priority 4.
// - serial 0 receive goes to offset 50h with priority 7.
// - serial 0 transmit goes to offset 54h with priority 8.
// - offset 58h, priority 9, is serial 2 receive or dma channel 0.
// - offset 5Ch, priority 10, is serial 2 transmit or dma channel 1.
// - the host port bit set by the host raises offset 64h, priority 12.
// - offset 68h, priority 13, is serial 1 receive or dma channel 2.
// - offset 6Ch, priority 14, is serial 1 transmit or dma channel 3.
// - an interprocessor request latches in flag bit 14 on its rise.
// - mask and flag share one bit per source at fixed positions.
module divp_vector_priority (
    clk_sys,
    rst_n,
    resetRequest,
    softResetTrap,
    nmiRequest,
    externalRequestZero,
    externalRequestOne,
    timerEvent,
    serial0RxEvent,
    serial0TxEvent,
    serial2RxEvent,
    serial2TxEvent,
    serial1RxEvent,
    serial1TxEvent,
    dmaChannelZeroEvent,
    dmaChannelOneEvent,
    dmaChannelTwoEvent,
    dmaChannelThreeEvent,
    dmaChannelFourEvent,
    dmaChannelFiveEvent,
    hostToCoreRequestBit,
    interprocessorEvent,
    dmaVectorSelect,
    interruptMask,
    globalEnable,
    flagClear,
    intAck,
    interruptFlagRegister,
    intPending,
    intVector,
    intPriority,
    intFlagIdx,
    resetTaken
);
    input  wire        clk_sys;
    input  wire        rst_n;
    input  wire        resetRequest;
    input  wire        softResetTrap;
    input  wire        nmiRequest;
    input  wire        externalRequestZero;
    input  wire        externalRequestOne;
    input  wire        timerEvent;
    input  wire        serial0RxEvent;
    input  wire        serial0TxEvent;
    input  wire        serial2RxEvent;
    input  wire        serial2TxEvent;
    input  wire        serial1RxEvent;
    input  wire        serial1TxEvent;
    input  wire        dmaChannelZeroEvent;
    input  wire        dmaChannelOneEvent;
    input  wire        dmaChannelTwoEvent;
    input  wire        dmaChannelThreeEvent;
    input  wire        dmaChannelFourEvent;
    input  wire        dmaChannelFiveEvent;
    input  wire        hostToCoreRequestBit;
    input  wire        interprocessorEvent;
    input  wire [3:0]  dmaVectorSelect;
    input  wire [15:0] interruptMask;
    input  wire        globalEnable;
    input  wire [15:0] flagClear;
    input  wire        intAck;
    output reg  [15:0] interruptFlagRegister;
    output reg         intPending;
    output reg  [6:0]  intVector;
    output reg  [4:0]  intPriority;
    output reg  [3:0]  intFlagIdx;
    output reg         resetTaken;

    // ******************************************************
    // source routing
    // ******************************************************
    // flag path
    wire [15:0] srcLevel;
    wire [15:0] flagNow;
    wire [15:0] ackClear;
    wire [15:0] clrBits;

    // arbitration and slot lookup
    wire [15:0] pendBits;
    wire        anyMaskable;
    wire [3:0]  winIdx;
    reg  [6:0]  slotVec;
    reg  [4:0]  slotPri;
    reg  [6:0]  nxt_vector;
    reg  [4:0]  nxt_priority;

    // nmi, reset and acknowledge state
    reg         nmiPrev_ff;
    reg         nmiFlag_ff;
    reg         ackBusy_ff;
    wire        nmiRise;
    wire        resetEvent;
    wire        ackTaken;
    wire        ackMaskable;

    // shared slots pick serial or dma by the select setting
    assign srcLevel[`DIVP_BIT_EXT0]   = externalRequestZero;
    assign srcLevel[`DIVP_BIT_EXT1]   = externalRequestOne;
    assign srcLevel[2]                = 1'b0;
    assign srcLevel[`DIVP_BIT_TIMER]  = timerEvent;
    assign srcLevel[`DIVP_BIT_SER0RX] = serial0RxEvent;
    assign srcLevel[`DIVP_BIT_SER0TX] = serial0TxEvent;
    assign srcLevel[`DIVP_BIT_SHR0]   = dmaVectorSelect[0] ?
        dmaChannelZeroEvent : serial2RxEvent;
    assign srcLevel[`DIVP_BIT_SHR1]   = dmaVectorSelect[1] ?
        dmaChannelOneEvent : serial2TxEvent;
    assign srcLevel[8]                = 1'b0;
    assign srcLevel[`DIVP_BIT_HOST]   = hostToCoreRequestBit;
    assign srcLevel[`DIVP_BIT_SHR2]   = dmaVectorSelect[2] ?
        dmaChannelTwoEvent : serial1RxEvent;
    assign srcLevel[`DIVP_BIT_SHR3]   = dmaVectorSelect[3] ?
        dmaChannelThreeEvent : serial1TxEvent;
    assign srcLevel[`DIVP_BIT_DMA4]   = dmaChannelFourEvent;
    assign srcLevel[`DIVP_BIT_DMA5]   = dmaChannelFiveEvent;
    assign srcLevel[`DIVP_BIT_IPROC]  = interprocessorEvent;
    assign srcLevel[15]               = 1'b0;

    // ******************************************************
    // flag latches
    // ******************************************************
    // an ack counts once per gap; it clears a flag only when the
    // offered vector was a maskable one, never for reset or nmi
    assign ackTaken    = intAck & intPending & ~ackBusy_ff;
    assign ackMaskable = ackTaken & (intPriority > `DIVP_PRI_NMI);
    assign ackClear    = ackMaskable ? (16'h0001 << intFlagIdx) :
        16'h0000;
    assign clrBits     = flagClear | ackClear;

    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : gFlag
            divp_edge_latch uLatch (
                .clk_sys  (clk_sys),
                .rst_n    (rst_n),
                .srcLevel (srcLevel[g]),
                .clrPulse (clrBits[g]),
                .flagOut  (flagNow[g])
            );
        end
    endgenerate

    // ******************************************************
    // arbitration
    // ******************************************************
    // flag bit order equals priority order, so lowest bit wins
    assign pendBits = flagNow & interruptMask & `DIVP_FLAG_USED &
        {16{globalEnable}};

    divp_pri_encode uEnc (
        .reqBits (pendBits),
        .anyReq  (anyMaskable),
        .winIdx  (winIdx)
    );

    assign nmiRise    = nmiRequest & ~nmiPrev_ff;
    assign resetEvent = resetRequest | softResetTrap;

    // ******************************************************
    // slot table
    // ******************************************************
    // vector offset of each flag bit; slots sit four words apart
    always @* begin
        case (winIdx)
            // external lines and timer
            4'h0:    slotVec = `DIVP_VEC_EXT0;
            4'h1:    slotVec = `DIVP_VEC_EXT1;
            4'h3:    slotVec = `DIVP_VEC_TIMER;
            // serial port zero
            4'h4:    slotVec = `DIVP_VEC_SER0RX;
            4'h5:    slotVec = `DIVP_VEC_SER0TX;
            // shared serial or dma slots and the host port
            4'h6:    slotVec = `DIVP_VEC_SHR0;
            4'h7:    slotVec = `DIVP_VEC_SHR1;
            4'h9:    slotVec = `DIVP_VEC_HOST;
            4'hA:    slotVec = `DIVP_VEC_SHR2;
            4'hB:    slotVec = `DIVP_VEC_SHR3;
            // dma four and five, interprocessor
            4'hC:    slotVec = `DIVP_VEC_DMA4;
            4'hD:    slotVec = `DIVP_VEC_DMA5;
            4'hE:    slotVec = `DIVP_VEC_IPROC;
            // reserved bits carry no source and are never offered
            4'h2, 4'h8, 4'hF:
                     slotVec = `DIVP_VEC_EXT0;
            default: slotVec = `DIVP_VEC_EXT0;
        endcase
    end

    // ******************************************************
    // priority table
    // ******************************************************
    // priority number of each flag bit; lower number wins
    always @* begin
        case (winIdx)
            // external lines and timer
            4'h0:    slotPri = 5'h03;
            4'h1:    slotPri = 5'h04;
            4'h3:    slotPri = 5'h06;
            // serial port zero
            4'h4:    slotPri = 5'h07;
            4'h5:    slotPri = 5'h08;
            // shared serial or dma slots and the host port
            4'h6:    slotPri = 5'h09;
            4'h7:    slotPri = 5'h0A;
            4'h9:    slotPri = 5'h0C;
            4'hA:    slotPri = 5'h0D;
            4'hB:    slotPri = 5'h0E;
            // dma four and five, interprocessor
            4'hC:    slotPri = 5'h0F;
            4'hD:    slotPri = 5'h10;
            4'hE:    slotPri = 5'h11;
            // reserved bits carry no source and are never offered
            4'h2, 4'h8, 4'hF:
                     slotPri = `DIVP_PRI_NONE;
            default: slotPri = `DIVP_PRI_NONE;
        endcase
    end

    // ******************************************************
    // offer selection
    // ******************************************************
    // reset first, then nmi, then the lowest pending flag bit
    always @* begin
        nxt_vector   = `DIVP_VEC_EXT0;
        nxt_priority = `DIVP_PRI_NONE;
        if (resetEvent) begin
            nxt_vector   = `DIVP_VEC_RESET;
            nxt_priority = `DIVP_PRI_RESET;
        end else if (nmiFlag_ff) begin
            nxt_vector   = `DIVP_VEC_NMI;
            nxt_priority = `DIVP_PRI_NMI;
        end else if (anyMaskable) begin
            nxt_vector   = slotVec;
            nxt_priority = slotPri;
        end
    end

    // ******************************************************
    // registered outputs
    // ******************************************************
    // nmi is edge latched and leaves on acknowledge, edge wins
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            nmiPrev_ff <= 1'b0;
            nmiFlag_ff <= 1'b0;
        end else begin
            nmiPrev_ff <= nmiRequest;
            if (nmiRise)
                nmiFlag_ff <= 1'b1;
            else if (ackTaken & (intPriority == `DIVP_PRI_NMI))
                nmiFlag_ff <= 1'b0;
        end
    end

    // flag mirror seen by the core; reserved bits read zero
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            interruptFlagRegister <= `DIVP_FLAG_RESET;
        end else begin
            interruptFlagRegister <= flagNow & `DIVP_FLAG_USED;
        end
    end

    // reset seen flag and the one cycle gap after a taken ack
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            resetTaken <= 1'b0;
            ackBusy_ff <= 1'b0;
        end else begin
            resetTaken <= resetEvent;
            ackBusy_ff <= ackTaken;
        end
    end

    // present winner one cycle after its flag; drop it on a taken ack
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            intPending  <= 1'b0;
            intVector   <= `DIVP_VEC_RESET;
            intPriority <= `DIVP_PRI_NONE;
            intFlagIdx  <= 4'h0;
        end else if (ackTaken) begin
            intPending  <= 1'b0;
            intPriority <= `DIVP_PRI_NONE;
        end else begin
            intPending  <= resetEvent | nmiFlag_ff | anyMaskable;
            intVector   <= nxt_vector;
            intPriority <= nxt_priority;
            intFlagIdx  <= winIdx;
        end
    end
endmodule // divp_vector_priority

// ---- verif/divp_vector_priority_asserts.sv ----
// concurrent checks of vectors, priorities and flags
`timescale 1ns/1ps
module divp_vector_priority_asserts (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        resetRequest,
    input wire logic        softResetTrap,
    input wire logic        serial2RxEvent,
    input wire logic        dmaChannelThreeEvent,
    input wire logic        hostToCoreRequestBit,
    input wire logic        interprocessorEvent,
    input wire logic [3:0]  dmaVectorSelect,
    input wire logic [15:0] interruptMask,
    input wire logic [15:0] interruptFlagRegister,
    input wire logic        intPending,
    input wire logic [6:0]  intVector,
    input wire logic [4:0]  intPriority,
    input wire logic [3:0]  intFlagIdx
);
    // ******************************
    // one clock domain, one reset
    // ******************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    AST_RESET_VEC: assert property (
        (resetRequest || softResetTrap)[*2] |->
        intVector == 7'h00 && intPriority == 5'h01) else $error("reset vector");
    AST_RESERVED: assert property (
        (interruptFlagRegister & 16'h8104) == 16'h0000 &&
        intVector != 7'h48 && intVector != 7'h60) else $error("reserved slot");
    AST_SLOT_STEP: assert property (
        intPending && intPriority > 5'h02 |->
        intVector == 7'h40 + {1'b0, intFlagIdx, 2'b00}) else $error("slot");
    AST_PRI_NUM: assert property (
        intPending && intVector >= 7'h40 |->
        intPriority == {1'b0, intFlagIdx} + 5'h03) else $error("priority");
    AST_LOWEST_WINS: assert property (
        intPending && $past(intPending) && intPriority > 5'h02 &&
        $stable(interruptMask) && $stable(interruptFlagRegister) |->
        (interruptFlagRegister & interruptMask &
         ((16'h0001 << intFlagIdx) - 16'h0001)) == 16'h0000)
        else $error("winner not lowest");
    AST_SER2_RX: assert property (
        $rose(serial2RxEvent) && !dmaVectorSelect[0] &&
        $stable(dmaVectorSelect) |-> ##[0:3] interruptFlagRegister[6])
        else $error("serial2 rx flag");
    AST_DMA3: assert property (
        $rose(dmaChannelThreeEvent) && dmaVectorSelect[3] &&
        $stable(dmaVectorSelect) |-> ##[0:3] interruptFlagRegister[11])
        else $error("dma3 flag");
    AST_HOST: assert property (
        $rose(hostToCoreRequestBit) |-> ##[0:3] interruptFlagRegister[9])
        else $error("host flag");
    AST_IPROC: assert property (
        $rose(interprocessorEvent) |-> ##[0:3] interruptFlagRegister[14])
        else $error("interprocessor flag");
endmodule // divp_vector_priority_asserts
bind divp_vector_priority divp_vector_priority_asserts chk_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .resetRequest(resetRequest),
    .softResetTrap(softResetTrap), .serial2RxEvent(serial2RxEvent),
    .dmaChannelThreeEvent(dmaChannelThreeEvent),
    .hostToCoreRequestBit(hostToCoreRequestBit),
    .interprocessorEvent(interprocessorEvent),
    .dmaVectorSelect(dmaVectorSelect), .interruptMask(interruptMask),
    .interruptFlagRegister(interruptFlagRegister), .intPending(intPending),
    .intVector(intVector), .intPriority(intPriority),
    .intFlagIdx(intFlagIdx));

// ---- verif/divp_core_model.sv ----
// core side model that takes offered vectors
`timescale 1ns/1ps
module divp_core_model (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       intPending,
    input wire logic       ackOn,
    input wire logic [1:0] ackDelay,
    output logic           intAck
);
    logic [1:0] waitCnt_ff;
    // ack after a chosen wait, never two acks back to back
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            intAck <= 1'b0;
            waitCnt_ff <= 2'h0;
        end else begin
            intAck <= 1'b0;
            waitCnt_ff <= 2'h0;
            if (intPending && ackOn && !intAck) begin
                if (waitCnt_ff == ackDelay) intAck <= 1'b1;
                else waitCnt_ff <= waitCnt_ff + 2'h1;
            end
        end
    end
endmodule // divp_core_model

// ---- verif/dsp_interrupt_vector_priority_bench.sv ----
// self-checking bench of the interrupt vector and priority block
`timescale 1ns/1ps
module dsp_interrupt_vector_priority_bench;
    logic        clk_sys = 1'b0, rst_n = 1'b0;
    logic [15:0] ev = 16'h0000, msk = 16'h0000, clr = 16'h0000;
    logic [5:0]  dv = 6'h00;
    logic [3:0]  sel = 4'h0, idx;
    logic        rstReq = 0, swRst = 0, nmi = 0, ge = 0, ackOn = 0;
    logic [1:0]  ackDly = 2'h0;
    logic        intAck, pend, rstTaken, useDma;
    logic [15:0] flags;
    logic [6:0]  vec;
    logic [4:0]  pri;
    logic [11:0] slot;
    integer      bad_count = 0, cmp_count = 0, cyc = 0, seed = 31, i, k;
    always #12.5 clk_sys = ~clk_sys;
    divp_vector_priority divp_vector_priority_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .resetRequest(rstReq),
        .softResetTrap(swRst), .nmiRequest(nmi),
        .externalRequestZero(ev[0]), .externalRequestOne(ev[1]),
        .timerEvent(ev[3]), .serial0RxEvent(ev[4]), .serial0TxEvent(ev[5]),
        .serial2RxEvent(ev[6]), .serial2TxEvent(ev[7]),
        .serial1RxEvent(ev[10]), .serial1TxEvent(ev[11]),
        .dmaChannelZeroEvent(dv[0]), .dmaChannelOneEvent(dv[1]),
        .dmaChannelTwoEvent(dv[2]), .dmaChannelThreeEvent(dv[3]),
        .dmaChannelFourEvent(dv[4]), .dmaChannelFiveEvent(dv[5]),
        .hostToCoreRequestBit(ev[9]), .interprocessorEvent(ev[14]),
        .dmaVectorSelect(sel), .interruptMask(msk), .globalEnable(ge),
        .flagClear(clr), .intAck(intAck), .interruptFlagRegister(flags),
        .intPending(pend), .intVector(vec), .intPriority(pri),
        .intFlagIdx(idx), .resetTaken(rstTaken));
    divp_core_model divp_core_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .intPending(pend), .ackOn(ackOn), .ackDelay(ackDly),
        .intAck(intAck));
    task tick(input integer n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // vector offset and priority of each flag bit, from the slot table
    function automatic logic [11:0] exp_slot(input integer b);
        case (b)
            0: exp_slot = {7'h40, 5'h03};
            1: exp_slot = {7'h44, 5'h04};
            3: exp_slot = {7'h4C, 5'h06};
            4: exp_slot = {7'h50, 5'h07};
            5: exp_slot = {7'h54, 5'h08};
            6: exp_slot = {7'h58, 5'h09};
            7: exp_slot = {7'h5C, 5'h0A};
            9: exp_slot = {7'h64, 5'h0C};
            10: exp_slot = {7'h68, 5'h0D};
            11: exp_slot = {7'h6C, 5'h0E};
            12: exp_slot = {7'h70, 5'h0F};
            13: exp_slot = {7'h74, 5'h10};
            14: exp_slot = {7'h78, 5'h11};
            default: exp_slot = {7'h00, 5'h1F};
        endcase
    endfunction
    task chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // raise one source for two cycles, then let the flag settle
    task pulse(input logic d, input integer b);
        if (d) dv[b] <= 1'b1;
        else ev[b] <= 1'b1;
        tick(2);
        dv <= 6'h00;
        ev <= 16'h0000;
        tick(4);
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            give_verdict;
        end
    end
    // *************************
    // main sequence
    // *************************
    initial begin
        tick(20);
        chk("idle pri", pri, 5'h1F);
        chk("idle vec", vec | flags | pend, 16'h0000);
        rst_n <= 1'b1;
        ge <= 1'b1;
        for (i = 0; i < 16; i++) begin
            msk <= 16'h0001 << i;
            sel <= 4'($random(seed));
            tick(1);
            if (i == 2 || i == 8 || i == 15) begin
                ev <= 16'hFFFF;
                pulse(1'b1, 0);
                chk("reserved", {flags[i], pend}, 16'h0000);
                clr <= 16'hFFFF;
                tick(1);
                clr <= 16'h0000;
                tick(2);
            end else begin
                k = (i < 10) ? i - 6 : i - 8;
                useDma = (i == 12 || i == 13) ||
                    ((i == 6 || i == 7 || i == 10 || i == 11) && sel[k]);
                if (i == 6 || i == 7 || i == 10 || i == 11) begin
                    pulse(!useDma, useDma ? i : k);
                    chk("unrouted", flags[i], 1'b0);
                end
                pulse(useDma, useDma ? k : i);
                chk("flag", {flags[i], pend}, 16'h0003);
                slot = exp_slot(i);
                chk("vector", vec, slot[11:5]);
                chk("priority", pri, slot[4:0]);
                ackOn <= 1'b1;
                tick(8);
                ackOn <= 1'b0;
                chk("acked", {flags[i], pend}, 16'h0000);
            end
        end
        msk <= 16'hFFFF;
        ge <= 1'b0;
        ev <= 16'h4022;
        pulse(1'b0, 1);
        chk("refused", {flags, 15'h0, pend}, 32'h4022_0000);
        ge <= 1'b1;
        tick(3);
        chk("winner", vec, 7'h44);
        clr <= 16'h0002;
        tick(1);
        clr <= 16'h0000;
        tick(3);
        chk("next", vec, 7'h54);
        nmi <= 1'b1;
        tick(3);
        nmi <= 1'b0;
        chk("nmi", {vec, pri}, {7'h04, 5'h02});
        for (k = 0; k < 2; k++) begin
            {swRst, rstReq} <= 2'b01 << k;
            tick(3);
            chk("reset", {rstTaken, vec, pri}, {1'b1, 7'h00, 5'h01});
            {swRst, rstReq} <= 2'b00;
            tick(3);
        end
        ackOn <= 1'b1;
        tick(4);
        chk("nmi acked", {flags, vec}, {16'h4020, 7'h54});
        tick(26);
        chk("drained", {flags, 15'h0, pend}, 32'h0);
        sel <= 4'($random(seed));
        msk <= 16'($random(seed));
        repeat (400) begin
            ev <= 16'($random(seed));
            dv <= 6'($random(seed));
            ackDly <= 2'($random(seed));
            tick(1);
            slot = exp_slot(idx);
            if (pend && pri > 5'h02) begin
                chk("rnd vector", vec, slot[11:5]);
                chk("rnd priority", pri, slot[4:0]);
            end
        end
        ev <= 16'h0000;
        dv <= 6'h00;
        tick(120);
        chk("left", flags & msk, 16'h0000);
        give_verdict;
    end
endmodule // dsp_interrupt_vector_priority_bench
